// File: hw/psacrc_div.sv
`timescale 1ns/1ps
module psacrc_div #(
    parameter int W = 4
) (
    input  wire logic         clk_in,   // system clock
    input  wire logic         rst_n_in, // async reset, active low
    input  wire logic         en_in,    // run; low holds count at zero
    input  wire logic [W-1:0] div_in,   // divide by div_in + 1
    output logic              tick_out, // one pulse per period
    output logic              tog_out   // half rate square wave
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
        logic         tog;
    } psacrc_div_st_t;

    psacrc_div_st_t q, d;

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (!en_in) begin
            d.cnt = '0;
        end else if (q.cnt >= div_in) begin
            // >= so a smaller divisor written mid period ends it at once
            d.cnt  = '0;
            d.tick = 1'b1;
            d.tog  = ~q.tog;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '{cnt: '0, tick: 1'b0, tog: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign tick_out = q.tick;
    assign tog_out  = q.tog;
endmodule

// File: hw/psacrc_pkg.sv
package psacrc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [23:0] ADDR_CTRL = 24'hfffc40;
    localparam logic [23:0] ADDR_FAST = 24'hfffc42;
    localparam logic [23:0] ADDR_SLOW = 24'hfffc44;
    localparam logic [23:0] ADDR_AUX  = 24'hfffc46;

    // clock_reset_control
    localparam int          BIT_SLOW_SEL = 0;
    localparam int          BIT_FAST_SEL = 1;
    localparam int          BIT_PLL_PWD  = 2;
    localparam int          BIT_AUX1_EN  = 3;
    localparam int          BIT_AUX2_EN  = 4;
    localparam int          BIT_POR      = 5;
    localparam logic [7:0]  CTRL_RST     = 8'h26;

    // fast_clock_prescaler
    localparam int          MULT_MSB  = 6;
    localparam int          MULT_LSB  = 4;
    localparam int          SDIV_MSB  = 3;
    localparam int          SDIV_LSB  = 0;
    localparam logic [7:0]  FAST_RST  = 8'h4f;

    // slow_clock_prescaler and aux_clock_prescaler
    localparam logic [7:0]  SLOW_RST  = 8'hb6;
    localparam int          AUX2_MSB  = 7;
    localparam int          AUX2_LSB  = 4;
    localparam int          AUX1_MSB  = 3;
    localparam int          AUX1_LSB  = 0;
    localparam logic [7:0]  AUX_RST   = 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // pll multiplier codes and timing
    localparam logic [2:0]  MULT_X3      = 3'h3;
    localparam logic [2:0]  MULT_X4      = 3'h4;
    localparam logic [2:0]  MULT_X5      = 3'h5;
    localparam logic [13:0] POR_PRESET   = 14'h3fff;
    localparam logic [15:0] PLL_LOCK_DEF = 16'h0200;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [23:0] addr;
        logic [7:0]  wdata;
    } psacrc_bus_t;

    typedef struct packed {
        logic sys_tick;
        logic sys_pll;
        logic aux1_tick;
        logic aux2_tick;
        logic slow_clk;
    } psacrc_clks_t;

    typedef struct packed {
        logic        slow_sel;
        logic        fast_sel;
        logic        pll_pwd;
        logic        aux1_en;
        logic        aux2_en;
        logic        por;
        logic [2:0]  mult;
        logic [3:0]  sys_div;
        logic [7:0]  slow_div;
        logic [3:0]  aux1_div;
        logic [3:0]  aux2_div;
        logic [13:0] por_cnt;
        logic [15:0] lock_cnt;
        logic        pll_stable;
        logic        pll_stop;
        logic        main_good;
        logic        sys_pll;
        logic        slow_out;
        logic        chip_rst_n;
        logic [7:0]  rd_data;
    } psacrc_st_t;

endpackage

// File: hw/psacrc_sync3.sv
`timescale 1ns/1ps
module psacrc_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_in,   // system clock
    input  wire logic rst_n_in, // async reset, active low
    input  wire logic d_in,     // asynchronous level
    output logic      q_out     // filtered level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } psacrc_sync_st_t;

    psacrc_sync_st_t q, d;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always_comb begin
        d    = q;
        d.s1 = d_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.q = q.s3;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign q_out = q.q;
endmodule

// File: hw/psacrc_top.sv
// What this block does
// - pll multiplies main clock by three, four, five
// - fast select reads one until pll stable
// - writing one returns system clock to main
// - selected source passes one-to-sixteen divider
// - aux clocks come from main clock directly
// - power-up counter releases reset unless pin low
// - slow select picks prescaler or slow oscillator
// - fast select zero pll, one main, reset one
// - pll select ignored while down or unstable
// - power-down bit stops pll, resets to one
// - power-down set ignored while pll selected
// - aux one runs when enabled and main good
// - aux two runs when enabled and main good
// - power-on flag cleared only by writing zero
// - system divider divides by divisor plus one
// - multiplier codes three four five, reset four
// - slow clock is main over twice (divisor plus one)
// - aux clocks divide by divisor plus one
`timescale 1ns/1ps
module psacrc_top
    import psacrc_pkg::*;
#(
    parameter logic [13:0] POR_CYCLES      = POR_PRESET,
    parameter logic [15:0] PLL_LOCK_CYCLES = PLL_LOCK_DEF
) (
    input  wire logic                     clk_in,          // main clock
    input  wire logic                     rst_n_in,        // power-on reset
    input  wire psacrc_pkg::psacrc_bus_t  bus_in,          // register port
    output logic [7:0]                    rd_data_out,     // read data
    input  wire logic                     reset_pin_n_in,  // reset pin
    input  wire logic                     stop_main_osc_in,// pmm stop
    input  wire logic                     pmm_stop_pll_in, // pmm pll stop
    input  wire logic                     slow_osc_in,     // 32 kHz osc
    input  wire logic                     slow_osc_good_in,// osc toggling
    output psacrc_pkg::psacrc_clks_t      clk_out,         // derived clocks
    output logic                          pll_stop_out,    // pll off
    output logic [2:0]                    pll_mult_out,    // pll factor
    output logic                          main_good_out,   // main stable
    output logic                          chip_rst_n_out   // on-chip reset
);
    import psacrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    psacrc_st_t q, d;
    logic       pin_s;
    logic       osc_s;
    logic       osc_good_s;
    logic       sys_tick;
    logic       aux1_tick;
    logic       aux2_tick;
    logic       slow_tog;
    logic       wr_ctrl;
    logic       pll_run;

    localparam psacrc_st_t ST_RST = '{
        slow_sel:   CTRL_RST[BIT_SLOW_SEL],
        fast_sel:   CTRL_RST[BIT_FAST_SEL],
        pll_pwd:    CTRL_RST[BIT_PLL_PWD],
        aux1_en:    CTRL_RST[BIT_AUX1_EN],
        aux2_en:    CTRL_RST[BIT_AUX2_EN],
        por:        CTRL_RST[BIT_POR],
        mult:       FAST_RST[MULT_MSB:MULT_LSB],
        sys_div:    FAST_RST[SDIV_MSB:SDIV_LSB],
        slow_div:   SLOW_RST,
        aux1_div:   AUX_RST[AUX1_MSB:AUX1_LSB],
        aux2_div:   AUX_RST[AUX2_MSB:AUX2_LSB],
        por_cnt:    POR_CYCLES,
        lock_cnt:   16'h0000,
        pll_stable: 1'b0,
        pll_stop:   1'b1,
        main_good:  1'b0,
        sys_pll:    1'b0,
        slow_out:   1'b0,
        chip_rst_n: 1'b0,
        rd_data:    8'h00
    };

    ////////////////////////////////////////////////////////////////////////
    function automatic logic mult_ok(input logic [2:0] m);
        return (m == MULT_X3) || (m == MULT_X4) || (m == MULT_X5);
    endfunction

    function automatic logic [7:0] reg_read(input logic [23:0] a,
                                            input psacrc_st_t  s);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            ADDR_CTRL: begin
                r[BIT_SLOW_SEL] = s.slow_sel;
                r[BIT_FAST_SEL] = s.fast_sel;
                r[BIT_PLL_PWD]  = s.pll_pwd;
                r[BIT_AUX1_EN]  = s.aux1_en;
                r[BIT_AUX2_EN]  = s.aux2_en;
                r[BIT_POR]      = s.por;
            end
            ADDR_FAST: begin
                r[MULT_MSB:MULT_LSB] = s.mult;
                r[SDIV_MSB:SDIV_LSB] = s.sys_div;
            end
            ADDR_SLOW: r = s.slow_div;
            ADDR_AUX: begin
                r[AUX1_MSB:AUX1_LSB] = s.aux1_div;
                r[AUX2_MSB:AUX2_LSB] = s.aux2_div;
            end
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pins from outside the clock domain
    psacrc_sync3 #(.RST_VAL(1'b0)) u_pin_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (reset_pin_n_in),
        .q_out    (pin_s)
    );

    psacrc_sync3 #(.RST_VAL(1'b0)) u_osc_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (slow_osc_in),
        .q_out    (osc_s)
    );

    psacrc_sync3 #(.RST_VAL(1'b0)) u_good_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (slow_osc_good_in),
        .q_out    (osc_good_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // dividers; the system one runs whenever rst_n_in is high, even during on-chip reset
    psacrc_div #(.W(4)) u_sys_div (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .en_in    (1'b1),
        .div_in   (q.sys_div),
        .tick_out (sys_tick),
        .tog_out  ()
    );

    psacrc_div #(.W(4)) u_aux1_div (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .en_in    (q.aux1_en && q.main_good),
        .div_in   (q.aux1_div),
        .tick_out (aux1_tick),
        .tog_out  ()
    );

    psacrc_div #(.W(4)) u_aux2_div (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .en_in    (q.aux2_en && q.main_good),
        .div_in   (q.aux2_div),
        .tick_out (aux2_tick),
        .tog_out  ()
    );

    // toggling every divisor+1 cycles gives main / (2 * (divisor + 1))
    psacrc_div #(.W(8)) u_slow_div (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .en_in    (!q.slow_sel),
        .div_in   (q.slow_div),
        .tick_out (),
        .tog_out  (slow_tog)
    );

    ////////////////////////////////////////////////////////////////////////
    assign wr_ctrl = bus_in.wr && (bus_in.addr == ADDR_CTRL);
    assign pll_run = !q.pll_pwd && !pmm_stop_pll_in;

    always_comb begin
        d = q;

        // pll lock timer; a reserved code never locks
        d.pll_stop = !pll_run;
        if (!pll_run || !mult_ok(q.mult)) begin
            d.lock_cnt   = 16'h0000;
            d.pll_stable = 1'b0;
        end else if (q.lock_cnt >= PLL_LOCK_CYCLES) begin
            d.pll_stable = 1'b1;
        end else begin
            d.lock_cnt = q.lock_cnt + 1'b1;
        end

        // start-up timer doubles as the power-on delay
        if (stop_main_osc_in) begin
            d.por_cnt = POR_CYCLES;
        end else if (q.por_cnt != 14'h0000) begin
            d.por_cnt = q.por_cnt - 1'b1;
        end
        d.main_good = !stop_main_osc_in && (d.por_cnt == 14'h0000);
        // once released, a later oscillator stop does not reset the chip
        d.chip_rst_n = pin_s &&
                       (q.chip_rst_n || (q.por_cnt == 14'h0000));

        // source changes only at a divider boundary, never mid pulse
        if (sys_tick) begin
            d.sys_pll = !q.fast_sel;
        end

        d.slow_out = q.slow_sel ? osc_s : slow_tog;

        if (wr_ctrl) begin
            // oscillator only taken while it is seen toggling
            if (!bus_in.wdata[BIT_SLOW_SEL]) begin
                d.slow_sel = 1'b0;
            end else if (osc_good_s) begin
                d.slow_sel = 1'b1;
            end
            if (bus_in.wdata[BIT_FAST_SEL]) begin
                d.fast_sel = 1'b1;
            end else if (!q.pll_pwd && q.pll_stable) begin
                d.fast_sel = 1'b0;
            end
            // a write that also clears the select keeps the pll up unless that clear is refused
            if (!bus_in.wdata[BIT_PLL_PWD]) begin
                d.pll_pwd = 1'b0;
            end else if (q.fast_sel && d.fast_sel) begin
                d.pll_pwd = 1'b1;
            end
            d.aux1_en = bus_in.wdata[BIT_AUX1_EN];
            d.aux2_en = bus_in.wdata[BIT_AUX2_EN];
            if (!bus_in.wdata[BIT_POR]) begin
                d.por = 1'b0;
            end
        end

        if (bus_in.wr && (bus_in.addr == ADDR_FAST)) begin
            // no guard against writes while on pll: left to software
            d.mult    = bus_in.wdata[MULT_MSB:MULT_LSB];
            d.sys_div = bus_in.wdata[SDIV_MSB:SDIV_LSB];
            if (bus_in.wdata[MULT_MSB:MULT_LSB] != q.mult) begin
                d.lock_cnt   = 16'h0000;
                d.pll_stable = 1'b0;
            end
        end
        if (bus_in.wr && (bus_in.addr == ADDR_SLOW)) begin
            d.slow_div = bus_in.wdata;
        end
        if (bus_in.wr && (bus_in.addr == ADDR_AUX)) begin
            d.aux1_div = bus_in.wdata[AUX1_MSB:AUX1_LSB];
            d.aux2_div = bus_in.wdata[AUX2_MSB:AUX2_LSB];
        end

        d.rd_data = bus_in.rd ? reg_read(bus_in.addr, q) : 8'h00;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign rd_data_out    = q.rd_data;
    assign pll_stop_out   = q.pll_stop;
    assign pll_mult_out   = q.mult;
    assign main_good_out  = q.main_good;
    assign chip_rst_n_out = q.chip_rst_n;
    assign clk_out        = '{sys_tick:  sys_tick,
                              sys_pll:   q.sys_pll,
                              aux1_tick: aux1_tick,
                              aux2_tick: aux2_tick,
                              slow_clk:  q.slow_out};

    ////////////////////////////////////////////////////////////////////////
    // helper: cycles since last system tick, valid after a clean period
    logic [4:0] gap_q;
    logic       primed_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap_q    <= 5'h00;
            primed_q <= 1'b0;
        end else begin
            gap_q <= sys_tick ? 5'h00 : (gap_q + 5'h01);
            if (bus_in.wr && (bus_in.addr == ADDR_FAST)) begin
                primed_q <= 1'b0;
            end else if (sys_tick) begin
                primed_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_ctrl_wr;
        wr_ctrl;
    endsequence

    property p_fast_refused;
        s_ctrl_wr ##0 (!bus_in.wdata[BIT_FAST_SEL] && q.fast_sel &&
                       (q.pll_pwd || !q.pll_stable)) |=> q.fast_sel;
    endproperty
    a_fast_refused: assert property (p_fast_refused)
        else $error("pll selected while pll unusable");

    property p_fast_clear;
        s_ctrl_wr ##0 (!bus_in.wdata[BIT_FAST_SEL] && !q.pll_pwd &&
                       q.pll_stable) |=> !q.fast_sel;
    endproperty
    a_fast_clear: assert property (p_fast_clear)
        else $error("stable pll not selected");

    property p_fast_set;
        s_ctrl_wr ##0 bus_in.wdata[BIT_FAST_SEL] |=> q.fast_sel;
    endproperty
    a_fast_set: assert property (p_fast_set)
        else $error("return to main clock lost");

    property p_pwd_guard;
        s_ctrl_wr ##0 (bus_in.wdata[BIT_PLL_PWD] && !q.fast_sel &&
                       !q.pll_pwd) |=> !q.pll_pwd ##1 !q.pll_stop;
    endproperty
    a_pwd_guard: assert property (p_pwd_guard)
        else $error("pll stopped while selected");

    property p_por_keep;
        s_ctrl_wr ##0 bus_in.wdata[BIT_POR] |=> $stable(q.por);
    endproperty
    a_por_keep: assert property (p_por_keep)
        else $error("power-on flag changed by a one");

    property p_aux1_off;
        !(q.aux1_en && q.main_good) |=> !aux1_tick;
    endproperty
    a_aux1_off: assert property (p_aux1_off)
        else $error("aux one runs while gated");

    property p_aux2_off;
        !(q.aux2_en && q.main_good) |=> !aux2_tick;
    endproperty
    a_aux2_off: assert property (p_aux2_off)
        else $error("aux two runs while gated");

    property p_sys_period;
        sys_tick && primed_q |-> gap_q == {1'b0, q.sys_div};
    endproperty
    a_sys_period: assert property (p_sys_period)
        else $error("system divider period wrong");

    property p_src_switch;
        $changed(q.sys_pll) |-> $past(sys_tick);
    endproperty
    a_src_switch: assert property (p_src_switch)
        else $error("clock source switched mid period");

    property p_count_down;
        !stop_main_osc_in && (q.por_cnt != 14'h0000)
            |=> q.por_cnt == $past(q.por_cnt) - 14'h0001;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("start-up counter not counting down");

    property p_release;
        !q.chip_rst_n && (q.por_cnt == 14'h0000) && pin_s
            |=> q.chip_rst_n;
    endproperty
    a_release: assert property (p_release)
        else $error("on-chip reset not released");

    property p_osc_stop;
        stop_main_osc_in |=> !q.main_good && (q.por_cnt == POR_CYCLES);
    endproperty
    a_osc_stop: assert property (p_osc_stop)
        else $error("main good while oscillator stopped");
endmodule

// File: sim/psacrc_supervisor.sv
`timescale 1ns/1ps
module psacrc_supervisor #(
    parameter int HOLD = 4
) (
    input  wire logic clk_in,          // main clock
    input  wire logic rails_good_in,   // both rails above minimum
    output logic      reset_pin_n_out  // reset pin, active low
);
    int cnt_q;
    // pin falls at once on a sagging rail; stays low until HOLD cycles after the rails
    // return, which outlasts the decaying main clock
    always_ff @(posedge clk_in) begin
        if (!rails_good_in) begin
            cnt_q <= 0;
        end else if (cnt_q < HOLD) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign reset_pin_n_out = rails_good_in && (cnt_q == HOLD);
endmodule

// File: sim/psacrc_tb.sv
`timescale 1ns/1ps
module testbench;
    import psacrc_pkg::*;
    logic         clk_in, rst_n_in, pin_n, stop_osc, slow_osc, slow_good;
    logic         rails, pll_stop, main_good, chip_rst_n, pmm;
    logic [7:0]   rdat;
    logic [2:0]   mult;
    psacrc_bus_t  bus;
    psacrc_clks_t clks;
    int           error_cnt, checks, cyc, osc_cnt;

    psacrc_top #(.POR_CYCLES(14'h0010), .PLL_LOCK_CYCLES(16'h0008)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
        .rd_data_out(rdat), .reset_pin_n_in(pin_n),
        .stop_main_osc_in(stop_osc), .pmm_stop_pll_in(pmm),
        .slow_osc_in(slow_osc), .slow_osc_good_in(slow_good),
        .clk_out(clks), .pll_stop_out(pll_stop), .pll_mult_out(mult),
        .main_good_out(main_good), .chip_rst_n_out(chip_rst_n));
    psacrc_supervisor #(.HOLD(4)) sup (
        .clk_in(clk_in), .rails_good_in(rails), .reset_pin_n_out(pin_n));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // slow oscillator stand-in, period 14 main cycles
    always @(posedge clk_in) begin
        osc_cnt <= (osc_cnt == 6) ? 0 : osc_cnt + 1;
        if (osc_cnt == 6) begin
            slow_osc <= ~slow_osc;
        end
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task chkn(input string nm, input int e, input int g);
        checks++;
        if (g != e) begin
            error_cnt++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [23:0] a, output logic [7:0] d);
        @(posedge clk_in);
        bus <= '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00};
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1 d = rdat;
    endtask
    task rchk(input logic [23:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk8(nm, e, d);
    endtask
    // probe index, sampled after the wait rather than at the call
    task bit_at(input int n, input string nm, input logic e, input int s);
        repeat (n) @(posedge clk_in);
        #1 chk8(nm, {7'h0, e}, {7'h0, pick(s)});
    endtask
    function logic pick(input int s);
        case (s)
            0: return clks.sys_tick;
            1: return clks.aux1_tick;
            2: return clks.aux2_tick;
            3: return clks.slow_clk;
            4: return main_good;
            5: return chip_rst_n;
            6: return pll_stop;
            default: return clks.sys_pll;
        endcase
    endfunction
    // rise-to-rise spacing; 0 when nothing rises within the window
    task period(input int s, input int e, input string nm);
        int t, r1, p;
        logic prev;
        p = 0;
        r1 = -1;
        @(posedge clk_in);
        #1 prev = pick(s);
        for (t = 0; t < 60 && p == 0; t++) begin
            @(posedge clk_in);
            #1;
            if (pick(s) === 1'b1 && prev !== 1'b1) begin
                if (r1 < 0) begin
                    r1 = t;
                end else begin
                    p = t - r1;
                end
            end
            prev = pick(s);
        end
        chkn(nm, e, p);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task s_power_up;
        bit_at(30, "main_good", 1'b1, 4);
        #1 chk8("rst_pin_low", 8'h00, {7'h0, chip_rst_n});
        @(posedge clk_in);
        rails <= 1'b1;
        bit_at(15, "rst_release", 1'b1, 5);
    endtask
    task s_regs;
        rchk(ADDR_CTRL, 8'h26, "ctrl");
        rchk(ADDR_FAST, 8'h4f, "fast");
        rchk(ADDR_SLOW, 8'hb6, "slow");
        rchk(ADDR_AUX, 8'hff, "aux");
        rchk(ADDR_CTRL + 24'h1, 8'h00, "unmapped");
        wr(ADDR_CTRL, 8'h26);
        rchk(ADDR_CTRL, 8'h26, "por_w1");
        wr(ADDR_CTRL, 8'h06);
        rchk(ADDR_CTRL, 8'h06, "por_w0");
        wr(ADDR_CTRL, 8'h26);
        rchk(ADDR_CTRL, 8'h06, "por_stay");
    endtask
    task s_pll;
        logic [2:0] codes [3];
        logic [7:0] d;
        int n;
        codes = '{3'h3, 3'h5, 3'h4};
        wr(ADDR_CTRL, 8'h04);
        rchk(ADDR_CTRL, 8'h06, "pll_off_sel");
        for (n = 0; n < 3; n++) begin
            wr(ADDR_FAST, {1'b0, codes[n], 4'h1});
            #1 chk8("mult", {5'h0, codes[n]}, {5'h0, mult});
            rchk(ADDR_FAST, {1'b0, codes[n], 4'h1}, "fast_rb");
        end
        wr(ADDR_CTRL, 8'h02);
        bit_at(2, "pll_run", 1'b0, 6);
        wr(ADDR_CTRL, 8'h00);
        rchk(ADDR_CTRL, 8'h02, "unstable");
        d = 8'h02;
        for (n = 0; n < 20 && d !== 8'h00; n++) begin
            wr(ADDR_CTRL, 8'h00);
            rd(ADDR_CTRL, d);
        end
        chk8("locked", 8'h00, d);
        for (n = 0; n < 40 && clks.sys_pll !== 1'b1; n++) begin
            bit_at(1, "pll_up", 1'b0, 6);
        end
        bit_at(0, "on_pll", 1'b1, 7);
        wr(ADDR_CTRL, 8'h04);
        rchk(ADDR_CTRL, 8'h00, "pwd_refused");
        bit_at(0, "pll_kept", 1'b0, 6);
        period(0, 2, "sys_div2");
        wr(ADDR_CTRL, 8'h02);
        rchk(ADDR_CTRL, 8'h02, "back_main");
        bit_at(20, "on_main", 1'b0, 7);
        @(posedge clk_in);
        pmm <= 1'b1;
        bit_at(2, "pmm_stop", 1'b1, 6);
        @(posedge clk_in);
        pmm <= 1'b0;
        bit_at(2, "pmm_run", 1'b0, 6);
        wr(ADDR_CTRL, 8'h06);
        bit_at(2, "pll_down", 1'b1, 6);
    endtask
    task s_div;
        wr(ADDR_FAST, 8'h4f);
        period(0, 16, "sys_div16");
        wr(ADDR_AUX, 8'h72);
        wr(ADDR_CTRL, 8'h1e);
        period(1, 3, "aux1");
        period(2, 8, "aux2");
        @(posedge clk_in);
        stop_osc <= 1'b1;
        bit_at(3, "osc_stop", 1'b0, 4);
        period(1, 0, "aux1_nomain");
        period(2, 0, "aux2_nomain");
        @(posedge clk_in);
        stop_osc <= 1'b0;
        repeat (25) @(posedge clk_in);
        period(1, 3, "aux1_back");
        wr(ADDR_CTRL, 8'h16);
        period(1, 0, "aux1_off");
        period(2, 8, "aux2_on");
        wr(ADDR_CTRL, 8'h06);
    endtask
    task s_slow;
        wr(ADDR_SLOW, 8'h03);
        period(3, 8, "slow_pre");
        wr(ADDR_CTRL, 8'h07);
        rchk(ADDR_CTRL, 8'h06, "no_osc");
        @(posedge clk_in);
        slow_good <= 1'b1;
        repeat (5) @(posedge clk_in);
        wr(ADDR_CTRL, 8'h07);
        rchk(ADDR_CTRL, 8'h07, "osc_sel");
        repeat (8) @(posedge clk_in);
        period(3, 14, "slow_osc");
    endtask
    task s_pin;
        @(posedge clk_in);
        rails <= 1'b0;
        bit_at(8, "pin_drop", 1'b0, 5);
        @(posedge clk_in);
        rails <= 1'b1;
        bit_at(15, "pin_back", 1'b1, 5);
    endtask

    initial begin
        rst_n_in = 1'b0;
        bus = '0;
        stop_osc = 1'b0;
        slow_osc = 1'b0;
        slow_good = 1'b0;
        rails = 1'b0;
        pmm = 1'b0;
        error_cnt = 0;
        checks = 0;
        cyc = 0;
        osc_cnt = 0;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        s_power_up;
        s_regs;
        s_pll;
        s_div;
        s_slow;
        s_pin;
        wrap_up;
    end
endmodule
